// file: boot_word_model.sv
// Boot memory model answering the core's boot word fetches
`timescale 1ns/10ps
module boot_word_model (
   input  wire logic        i_ref_clk, // Clock
   input  wire logic        i_nrst,    // Sync reset, active low
   input  wire logic        i_slow,    // Add three wait cycles
   input  wire logic        i_valid,   // Fetch request
   input  wire logic [31:0] i_addr,    // Fetch address
   output logic             o_ready,   // Word returned pulse
   output logic      [31:0] o_data     // Word value
);
   logic [1:0] wait_cnt = 2'h0;
   initial o_ready = 1'b0;
   initial o_data = 32'h0;
   // Idle data is inverted each cycle so a stale word never passes
   always @(posedge i_ref_clk) begin
      o_ready <= 1'b0;
      o_data <= ~o_data;
      if (!i_nrst) begin
         wait_cnt <= 2'h0;
      end else if (i_valid && !o_ready) begin
         if (!i_slow || wait_cnt == 2'h3) begin
            o_ready <= 1'b1;
            o_data <= i_addr + 32'hA5F0_0000;
            wait_cnt <= 2'h0;
         end else begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule

// file: exception_vector_routing.sv
// Vector table base, boot fetch, vector lookup and fault/reset routing
//
// Summary of operation
// - Boot fetches the stack word at slot zero before any handler address.
// - System exceptions one to fifteen each own a slot relative to base.
// - Peripheral lines own slots for vectors sixteen to one hundred seven.
// - Any reset forces the table base back to zero.
// - Only privileged writes within the permitted range relocate the base.
// - Clock fail, expander error, NMI pin or NMI watchdog raise NMI.
// - Bus fault is precise-synchronous or imprecise-asynchronous.
// - Every programmable priority comes out of reset as zero.
// - Uncorrectable local or shared memory errors raise a bus fault.
// - Correctable single-bit errors become ordinary maskable interrupts.
// - Watchdogs take software reset; each drives one reset request bit.
// - NMI watchdog takes the NMI event and issues its own reset request.
// - Four interprocessor channels raise interrupts into the controller.
// - Converter EOC sources are ANDed pairwise and sent to both sides.
`timescale 1ns/10ps
module exception_vector_routing (
   input  wire logic        i_ref_clk,          // Subsystem clock, 125 MHz
   input  wire logic        i_nrst,             // Sync reset, active low
   output logic             o_boot_fetch_valid, // Boot word fetch request
   output logic      [31:0] o_boot_fetch_addr,  // Boot word address
   input  wire logic        i_boot_fetch_ready, // Boot word returned
   input  wire logic [31:0] i_boot_fetch_data,  // Boot word value
   output logic      [31:0] o_stack_ptr,        // Initial stack pointer
   output logic      [31:0] o_reset_handler,    // Reset handler address
   output logic             o_boot_done,        // Boot fetches complete
   input  wire logic        i_exc_valid,        // Vector lookup request
   input  wire logic [7:0]  i_exc_num,          // Vector number to look up
   output logic             o_vec_valid,        // Lookup answer pulse
   output logic      [31:0] o_vec_addr,         // Slot address of vector
   output logic signed [8:0] o_vec_prio,        // Priority of vector
   output logic             o_vec_reserved,     // Slot is reserved
   input  wire logic        i_vto_wr,           // Base offset write strobe
   input  wire logic        i_vto_priv,         // Writer is privileged
   input  wire logic [31:0] i_vto_data,         // Requested base
   output logic             o_vto_reject,       // Write refused pulse
   output logic      [31:0] o_vector_table_offset, // Current base
   input  wire logic        i_prio_wr,          // Priority write strobe
   input  wire logic [7:0]  i_prio_vec,         // Vector being set
   input  wire logic [7:0]  i_prio_data,        // New priority
   input  wire logic        i_clock_fail,       // Clock failure
   input  wire logic        i_expander_err,     // Control expander error
   input  wire logic        i_nmi_pin,          // External NMI input
   input  wire logic        i_nmi_wd_timeout,   // Control NMI wd time-out
   output logic             o_nmi,              // NMI exception request
   output logic             o_nonmaskable_event, // Event to NMI watchdog
   input  wire logic        i_nmi_wd_expired,   // NMI watchdog expired
   output logic             o_nonmaskable_watchdog_reset_request, // Rst req
   input  wire logic        i_software_reset_request, // From controller
   input  wire logic [1:0]  i_wd_expired,       // Watchdog expiries
   output logic      [1:0]  o_software_reset_to_wd, // To both watchdogs
   output logic      [1:0]  o_watchdog_reset_requests, // To reset block
   input  wire logic        i_precise_fault,    // Precise access error
   input  wire logic        i_imprecise_fault,  // Imprecise access error
   input  wire logic        i_ram_uncorr,       // RAM uncorrectable error
   input  wire logic        i_flash_uncorr,     // Flash uncorrectable
   input  wire logic        i_shared_uncorr,    // Shared RAM uncorrectable
   input  wire logic        i_busfault_ack,     // Imprecise fault taken
   output logic             o_busfault_precise, // Synchronous fault pulse
   output logic             o_busfault_imprecise, // Pending async fault
   input  wire logic [91:0] i_periph_irq,       // Peripheral requests
   input  wire logic        i_ram_single_err,   // RAM correctable error
   input  wire logic        i_flash_single_err, // Flash correctable error
   input  wire logic [3:0]  i_ipc_irq,          // Interrupting channels
   input  wire logic [7:0]  i_adc1_eoc,         // First converter EOC
   input  wire logic [7:0]  i_adc2_eoc,         // Second converter EOC
   output logic      [91:0] o_irq_lines,        // Lines to the controller
   output logic      [7:0]  o_adc_eoc_and       // Combined EOC, both sides
);
   typedef struct packed {
      vector_routing_pkg::boot_t st;
      logic [31:0]         base;
      logic [31:0]         stack_ptr;
      logic [31:0]         reset_handler;
      logic                vec_valid;
      logic [31:0]         vec_addr;
      logic signed [8:0]   vec_prio;
      logic                vec_rsvd;
      logic                vto_reject;
      logic [107:0][7:0]   prio;
      logic                nmi;
      logic                bf_precise;
      logic                bf_imprecise;
      logic [1:0]          wd_rst;
      logic                nmi_wd_rst;
   } state_t;

   state_t cur;
   state_t next_cur;

   // Slot address: base plus four times the vector number
   function automatic logic [31:0] slot_addr(input logic [31:0] base,
                                             input logic [7:0]  vec);
      slot_addr = base + ({24'h000000, vec} << vector_routing_pkg::SLOT_SHIFT);
   endfunction

   // Reserved slots and numbers past the last peripheral line
   function automatic logic is_reserved(input logic [7:0] vec);
      is_reserved = (vec >= vector_routing_pkg::VEC_RSVD_LO &&
                     vec <= vector_routing_pkg::VEC_RSVD_HI) ||
                    vec == vector_routing_pkg::VEC_RSVD_MID ||
                    vec == vector_routing_pkg::VEC_STACK ||
                    vec >  vector_routing_pkg::VEC_LAST_IRQ;
   endfunction

   // Vectors whose priority is hard-wired
   function automatic logic is_fixed(input logic [7:0] vec);
      is_fixed = vec == vector_routing_pkg::VEC_RESET ||
                 vec == vector_routing_pkg::VEC_NMI ||
                 vec == vector_routing_pkg::VEC_HARD_FAULT;
   endfunction

   logic base_ok;
   logic uncorr;

   // Next-state logic for boot, lookup, base, priorities and routing
   always_comb begin
      next_cur = cur;
      next_cur.vec_valid  = 1'b0;
      next_cur.vto_reject = 1'b0;
      // Alignment, range and privilege checked together
      base_ok = i_vto_priv &&
                (i_vto_data[8:0] & vector_routing_pkg::BASE_ALIGN_MSK)
                == 9'h000 &&
                i_vto_data >= vector_routing_pkg::BASE_MIN &&
                i_vto_data <= vector_routing_pkg::BASE_MAX;
      uncorr  = i_ram_uncorr | i_flash_uncorr | i_shared_uncorr;
      case (cur.st)
         vector_routing_pkg::BOOT_STACK: begin
            if (i_boot_fetch_ready) begin
               next_cur.stack_ptr = i_boot_fetch_data;
               next_cur.st        = vector_routing_pkg::BOOT_HANDLR;
            end
         end
         vector_routing_pkg::BOOT_HANDLR: begin
            if (i_boot_fetch_ready) begin
               next_cur.reset_handler = i_boot_fetch_data;
               next_cur.st            = vector_routing_pkg::BOOT_DONE;
            end
         end
         vector_routing_pkg::BOOT_DONE: begin
            next_cur.st = vector_routing_pkg::BOOT_DONE;
         end
         default: begin
            next_cur.st = vector_routing_pkg::BOOT_STACK;
         end
      endcase
      // Lookups are only answered once the boot words are in
      if (i_exc_valid && cur.st == vector_routing_pkg::BOOT_DONE) begin
         next_cur.vec_valid = 1'b1;
         next_cur.vec_addr  = slot_addr(cur.base, i_exc_num);
         next_cur.vec_rsvd  = is_reserved(i_exc_num);
         case (i_exc_num)
            vector_routing_pkg::VEC_RESET:
               next_cur.vec_prio = vector_routing_pkg::PRIO_RESET;
            vector_routing_pkg::VEC_NMI:
               next_cur.vec_prio = vector_routing_pkg::PRIO_NMI;
            vector_routing_pkg::VEC_HARD_FAULT:
               next_cur.vec_prio = vector_routing_pkg::PRIO_HARD;
            default: begin
               if (is_reserved(i_exc_num)) begin
                  next_cur.vec_prio = 9'sh000;
               end else begin
                  next_cur.vec_prio = {1'b0, cur.prio[i_exc_num]};
               end
            end
         endcase
      end
      // Relocation; a refused write leaves the base untouched
      if (i_vto_wr) begin
         if (base_ok) begin
            next_cur.base = i_vto_data;
         end else begin
            next_cur.vto_reject = 1'b1;
         end
      end
      // Fixed and reserved slots ignore priority writes
      if (i_prio_wr && !is_fixed(i_prio_vec) && !is_reserved(i_prio_vec))
      begin
         next_cur.prio[i_prio_vec] = i_prio_data;
      end
      next_cur.nmi = i_clock_fail | i_expander_err | i_nmi_pin |
                     i_nmi_wd_timeout;
      next_cur.bf_precise = i_precise_fault;
      // Pending async fault: a new event wins over the acknowledge
      if (i_busfault_ack) begin
         next_cur.bf_imprecise = 1'b0;
      end
      if (i_imprecise_fault || uncorr) begin
         next_cur.bf_imprecise = 1'b1;
      end
      next_cur.wd_rst     = i_wd_expired;
      next_cur.nmi_wd_rst = i_nmi_wd_expired;
      if (!i_nrst) begin
         next_cur      = '0;
         next_cur.st   = vector_routing_pkg::BOOT_STACK;
         next_cur.base = vector_routing_pkg::BASE_AT_RESET;
         for (int v = 0; v < vector_routing_pkg::NUM_VECTORS; v++) begin
            next_cur.prio[v] = vector_routing_pkg::PRIO_DEFAULT;
         end
      end
   end

   // Single state register
   always_ff @(posedge i_ref_clk) begin
      cur <= next_cur;
   end

   // Boot fetch reads slot zero, then the reset slot, at the reset base
   assign o_boot_fetch_valid = cur.st != vector_routing_pkg::BOOT_DONE;
   assign o_boot_fetch_addr  = (cur.st == vector_routing_pkg::BOOT_STACK) ?
      slot_addr(cur.base, vector_routing_pkg::VEC_STACK) :
      slot_addr(cur.base, vector_routing_pkg::VEC_RESET);
   assign o_stack_ptr           = cur.stack_ptr;
   assign o_reset_handler       = cur.reset_handler;
   assign o_boot_done           = cur.st == vector_routing_pkg::BOOT_DONE;
   assign o_vec_valid           = cur.vec_valid;
   assign o_vec_addr            = cur.vec_addr;
   assign o_vec_prio            = cur.vec_prio;
   assign o_vec_reserved        = cur.vec_rsvd;
   assign o_vto_reject          = cur.vto_reject;
   assign o_vector_table_offset = cur.base;
   // The NMI event doubles as the NMI watchdog's input
   assign o_nmi                 = cur.nmi;
   assign o_nonmaskable_event   = cur.nmi;
   assign o_nonmaskable_watchdog_reset_request = cur.nmi_wd_rst;
   // Software reset is fanned out unregistered to both watchdogs
   assign o_software_reset_to_wd    = {2{i_software_reset_request}};
   assign o_watchdog_reset_requests = cur.wd_rst;
   assign o_busfault_precise        = cur.bf_precise;
   assign o_busfault_imprecise      = cur.bf_imprecise;

   irq_line_router u_router (
      .i_ref_clk          (i_ref_clk),
      .i_nrst             (i_nrst),
      .i_periph_irq       (i_periph_irq),
      .i_ram_single_err   (i_ram_single_err),
      .i_flash_single_err (i_flash_single_err),
      .i_ipc_irq          (i_ipc_irq),
      .i_adc1_eoc         (i_adc1_eoc),
      .i_adc2_eoc         (i_adc2_eoc),
      .o_irq_lines        (o_irq_lines),
      .o_adc_eoc_and      (o_adc_eoc_and)
   );

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);

   stack_first_a: assert property (
      cur.st == vector_routing_pkg::BOOT_STACK && i_boot_fetch_ready |=>
      o_stack_ptr == $past(i_boot_fetch_data) && !o_boot_done &&
      o_boot_fetch_addr == slot_addr(cur.base, 8'h01))
      else $error("Stack word not taken first");
   slot_addr_a: assert property (
      i_exc_valid && o_boot_done |=> o_vec_valid &&
      o_vec_addr == $past(cur.base) + {22'h000000, $past(i_exc_num), 2'b00})
      else $error("Vector slot address wrong");
   irq_slot_a: assert property (
      i_exc_valid && o_boot_done && i_exc_num >= 8'h10 &&
      i_exc_num <= 8'h6B |=> !o_vec_reserved)
      else $error("Peripheral vector marked reserved");
   irq_vec_a: assert property (
      i_exc_valid && o_boot_done && i_exc_num == 8'h58 |=>
      o_vec_addr == cur.base + 32'h0000_0160 || $past(i_vto_wr))
      else $error("Irq 72 not at offset 0x160");
   base_reset_a: assert property (disable iff (1'b0)
      !i_nrst |=> o_vector_table_offset == 32'h0000_0000)
      else $error("Base not zero after reset");
   unpriv_wr_a: assert property (
      i_vto_wr && !i_vto_priv |=> o_vto_reject &&
      o_vector_table_offset == $past(o_vector_table_offset))
      else $error("Unprivileged base write accepted");
   align_chk_a: assert property (
      i_vto_wr && i_vto_data[8:0] != 9'h000 |=> o_vto_reject)
      else $error("Misaligned base accepted");
   nmi_src_a: assert property (
      i_clock_fail || i_expander_err || i_nmi_pin || i_nmi_wd_timeout |=>
      o_nmi && o_nonmaskable_event)
      else $error("NMI source did not raise NMI");
   bf_precise_a: assert property (
      i_precise_fault |=> o_busfault_precise ##1
      (o_busfault_precise == $past(i_precise_fault)))
      else $error("Precise bus fault not synchronous");
   fixed_prio_a: assert property (
      i_exc_valid && o_boot_done && i_exc_num == 8'h02 |=>
      o_vec_prio == -9'sd2)
      else $error("NMI priority not minus two");
   prio_zero_a: assert property (disable iff (1'b0)
      !i_nrst |=> cur.prio == '0)
      else $error("Priorities not zero after reset");
   bf_mem_a: assert property (
      (i_ram_uncorr || i_shared_uncorr) |=> o_busfault_imprecise [*1]
      ##0 (o_busfault_imprecise || $past(i_busfault_ack)) )
      else $error("Uncorrectable error lost");
   wd_req_a: assert property (
      i_wd_expired[1] |=> o_watchdog_reset_requests[1])
      else $error("Watchdog reset request missing");
   nmi_wd_a: assert property (
      i_nmi_wd_expired |=> o_nonmaskable_watchdog_reset_request)
      else $error("NMI watchdog reset request missing");

   boot_cov_c:  cover property (o_boot_fetch_valid ##[1:20] o_boot_done);
   reloc_cov_c: cover property (i_vto_wr && base_ok ##1 !o_vto_reject);
   bf_cov_c:    cover property (o_busfault_imprecise ##1 i_busfault_ack);
endmodule

// file: irq_line_router.sv
// Routing of memory, interprocessor and converter events onto irq lines
`timescale 1ns/10ps
module irq_line_router (
   input  wire logic        i_ref_clk,          // Subsystem clock
   input  wire logic        i_nrst,             // Sync reset, active low
   input  wire logic [91:0] i_periph_irq,       // Other peripheral requests
   input  wire logic        i_ram_single_err,   // RAM correctable error
   input  wire logic        i_flash_single_err, // Flash correctable error
   input  wire logic [3:0]  i_ipc_irq,          // Interrupting channels
   input  wire logic [7:0]  i_adc1_eoc,         // First converter EOC
   input  wire logic [7:0]  i_adc2_eoc,         // Second converter EOC
   output logic      [91:0] o_irq_lines,        // Lines to the controller
   output logic      [7:0]  o_adc_eoc_and       // Combined EOC, both sides
);
   typedef struct packed {
      logic [91:0] lines;
      logic [7:0]  eoc;
   } route_t;

   route_t cur;
   route_t next_cur;

   // Merge routed events into their fixed bit positions
   always_comb begin
      next_cur.lines = i_periph_irq;
      next_cur.eoc   = i_adc1_eoc & i_adc2_eoc;
      for (int k = 0; k < vector_routing_pkg::NUM_ADC_EOC; k++) begin
         next_cur.lines[vector_routing_pkg::IRQ_ADC_FIRST + k] =
            i_periph_irq[vector_routing_pkg::IRQ_ADC_FIRST + k] |
            next_cur.eoc[k];
      end
      for (int k = 0; k < vector_routing_pkg::NUM_IPC_IRQ; k++) begin
         next_cur.lines[vector_routing_pkg::IRQ_IPC_FIRST + k] =
            i_periph_irq[vector_routing_pkg::IRQ_IPC_FIRST + k] |
            i_ipc_irq[k];
      end
      // Correctable errors stay maskable rather than faulting
      next_cur.lines[vector_routing_pkg::IRQ_RAM_SINGLE] =
         i_periph_irq[vector_routing_pkg::IRQ_RAM_SINGLE] |
         i_ram_single_err;
      next_cur.lines[vector_routing_pkg::IRQ_FLASH_SGL] =
         i_periph_irq[vector_routing_pkg::IRQ_FLASH_SGL] |
         i_flash_single_err;
      if (!i_nrst) begin
         next_cur = '0;
      end
   end

   // One register stage for all routed lines
   always_ff @(posedge i_ref_clk) begin
      cur <= next_cur;
   end

   assign o_irq_lines   = cur.lines;
   assign o_adc_eoc_and = cur.eoc;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);

   single_err_irq_a: assert property (i_ram_single_err |=>
      o_irq_lines[vector_routing_pkg::IRQ_RAM_SINGLE])
      else $error("RAM single error not routed to irq line");
   ipc_irq_a: assert property (i_ipc_irq[0] |=>
      o_irq_lines[vector_routing_pkg::IRQ_IPC_FIRST])
      else $error("IPC channel interrupt not routed");
   adc_and_a: assert property (1'b1 |=>
      o_adc_eoc_and == ($past(i_adc1_eoc) & $past(i_adc2_eoc)))
      else $error("Combined EOC is not the AND of both converters");
   eoc_cov_c: cover property (o_adc_eoc_and != 8'h00);
endmodule

// file: tb.sv
// Self-checking bench for vector lookup, base relocation and event routing
`timescale 1ns/10ps
module tb;
   logic i_ref_clk = 1'b0, i_nrst = 1'b0, slow = 1'b0, exp_imp = 1'b0;
   logic i_exc_valid = 1'b0, i_vto_wr = 1'b0, i_vto_priv = 1'b0;
   logic i_prio_wr = 1'b0, i_clock_fail = 1'b0, i_expander_err = 1'b0;
   logic i_nmi_pin = 1'b0, i_nmi_wd_timeout = 1'b0, i_nmi_wd_expired = 1'b0;
   logic i_software_reset_request = 1'b0, i_precise_fault = 1'b0;
   logic i_imprecise_fault = 1'b0, i_ram_uncorr = 1'b0;
   logic i_flash_uncorr = 1'b0, i_shared_uncorr = 1'b0, i_busfault_ack = 1'b0;
   logic i_ram_single_err = 1'b0, i_flash_single_err = 1'b0;
   logic [1:0] i_wd_expired = 2'h0;
   logic [3:0] i_ipc_irq = 4'h0;
   logic [7:0] i_exc_num = 8'h00, i_prio_vec = 8'h00, i_prio_data = 8'h00;
   logic [7:0] i_adc1_eoc = 8'h00, i_adc2_eoc = 8'h00, o_adc_eoc_and;
   logic [31:0] i_vto_data = 32'h0, base = 32'h0;
   logic [91:0] i_periph_irq = '0, o_irq_lines;
   logic i_boot_fetch_ready, o_boot_fetch_valid, o_boot_done, o_vec_valid;
   logic o_vec_reserved, o_vto_reject, o_nmi, o_nonmaskable_event;
   logic o_nonmaskable_watchdog_reset_request, o_busfault_precise;
   logic o_busfault_imprecise;
   logic [1:0] o_software_reset_to_wd, o_watchdog_reset_requests;
   logic [31:0] i_boot_fetch_data, o_boot_fetch_addr, o_stack_ptr;
   logic [31:0] o_reset_handler, o_vec_addr, o_vector_table_offset;
   logic signed [8:0] o_vec_prio;
   logic [127:0] rnd;
   logic [7:0] prio_tab [256];
   int failures = 0, check_count = 0, cyc = 0;
   exception_vector_routing i_dut (.*);
   boot_word_model i_mem (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_slow(slow), .i_valid(o_boot_fetch_valid), .i_addr(o_boot_fetch_addr),
      .o_ready(i_boot_fetch_ready), .o_data(i_boot_fetch_data));
   initial forever #4 i_ref_clk = ~i_ref_clk;
   task stop_test;
      if (failures == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Hang guard, well above the length of the whole sequence
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         stop_test;
      end
   end
   task check(input logic [91:0] got, input logic [91:0] exp, string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h", $time, what, got);
      end
   endtask
   function automatic logic rsvd(input logic [7:0] n);
      return n == 8'h00 || (n >= 8'h07 && n <= 8'h0A) || n == 8'h0D
         || n > 8'h6B;
   endfunction
   function automatic logic [91:0] exp_irq();
      logic [91:0] e;
      e = i_periph_irq;
      for (int i = 0; i < 8; i++) e[72+i] |= i_adc1_eoc[i] & i_adc2_eoc[i];
      for (int i = 0; i < 4; i++) e[80+i] |= i_ipc_irq[i];
      e[88] |= i_ram_single_err;
      e[90] |= i_flash_single_err;
      return e;
   endfunction
   // Reset, then a lookup that must be ignored while boot is in progress
   task do_reset;
      i_nrst <= 1'b0;
      repeat (5) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      base = 32'h0;
      exp_imp = 1'b0;
      foreach (prio_tab[i]) prio_tab[i] = 8'h00;
      @(posedge i_ref_clk);
      i_exc_valid <= 1'b1;
      @(posedge i_ref_clk);
      i_exc_valid <= 1'b0;
      @(negedge i_ref_clk);
      check(o_vec_valid, 1'b0, "early lookup");
      for (int i = 0; i < 40 && o_boot_done !== 1'b1; i++)
         @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      check(o_stack_ptr, 32'hA5F0_0000, "stack");
      check(o_reset_handler, 32'hA5F0_0004, "handler");
      check(o_vector_table_offset, 32'h0, "base");
   endtask
   task lookup(input logic [7:0] n);
      logic signed [8:0] ep;
      ep = rsvd(n) ? 9'sh000 : n == 8'h01 ? vector_routing_pkg::PRIO_RESET
         : n == 8'h02 ? vector_routing_pkg::PRIO_NMI : n == 8'h03
         ? vector_routing_pkg::PRIO_HARD : $signed({1'b0, prio_tab[n]});
      @(posedge i_ref_clk);
      i_exc_valid <= 1'b1;
      i_exc_num <= n;
      @(posedge i_ref_clk);
      i_exc_valid <= 1'b0;
      @(negedge i_ref_clk);
      check(o_vec_valid, 1'b1, "valid");
      check(o_vec_addr, base + {n, 2'b00}, "addr");
      check(o_vec_reserved, rsvd(n), "reserved");
      check(o_vec_prio, ep, "prio");
   endtask
   task set_prio(input logic [7:0] n, input logic [7:0] d);
      @(posedge i_ref_clk);
      {i_prio_wr, i_prio_vec, i_prio_data} <= {1'b1, n, d};
      @(posedge i_ref_clk);
      i_prio_wr <= 1'b0;
      if (!rsvd(n) && n > 8'h03) prio_tab[n] = d;
   endtask
   task set_base(input logic p, input logic [31:0] d);
      logic ok;
      ok = p && d[8:0] == 9'h000 && d >= 32'h200 && d <= 32'h3FFF_FE00;
      @(posedge i_ref_clk);
      {i_vto_wr, i_vto_priv, i_vto_data} <= {1'b1, p, d};
      @(posedge i_ref_clk);
      i_vto_wr <= 1'b0;
      @(negedge i_ref_clk);
      if (ok) base = d;
      check(o_vto_reject, !ok, "reject");
      check(o_vector_table_offset, base, "base");
   endtask
   initial begin
      void'($urandom(32'hE38BD867));
      do_reset;
      for (int n = 0; n < 111; n++) lookup(n[7:0]);
      for (int i = 0; i < 6; i++) begin
         rnd[7:0] = {8'h05, 8'h02, 8'h0B, 8'h6B, 8'h6C, 8'h0D} >> (8 * i);
         set_prio(rnd[7:0], 8'($urandom));
         lookup(rnd[7:0]);
      end
      set_base(1'b1, 32'h0000_0200);
      set_base(1'b1, 32'h0000_0100);
      set_base(1'b1, 32'h0000_0410);
      set_base(1'b0, 32'h0000_0800);
      set_base(1'b1, 32'h3FFF_FE00);
      set_base(1'b1, 32'h4000_0000);
      set_base(1'b1, $urandom & 32'h3FFF_FE00);
      lookup(8'h10);
      lookup(8'h6B);
      // Random event traffic; each value is held across two edges
      for (int k = 0; k < 200; k++) begin
         @(posedge i_ref_clk);
         rnd = {$urandom, $urandom, $urandom, $urandom};
         i_periph_irq <= rnd[91:0];
         {i_ram_single_err, i_flash_single_err, i_ipc_irq} <= rnd[97:92];
         {i_adc1_eoc, i_adc2_eoc} <= rnd[113:98];
         {i_clock_fail, i_expander_err, i_nmi_pin, i_nmi_wd_timeout}
            <= rnd[117:114] & {4{rnd[118]}};
         {i_nmi_wd_expired, i_software_reset_request} <= rnd[120:119];
         {i_wd_expired, i_precise_fault, i_busfault_ack} <= rnd[124:121];
         {i_imprecise_fault, i_ram_uncorr, i_flash_uncorr, i_shared_uncorr}
            <= rnd[3:0] & {4{rnd[4] & rnd[5]}};
         @(posedge i_ref_clk);
         @(negedge i_ref_clk);
         exp_imp = (exp_imp & !i_busfault_ack) | i_imprecise_fault
            | i_ram_uncorr | i_flash_uncorr | i_shared_uncorr;
         check(o_nmi, i_clock_fail | i_expander_err | i_nmi_pin
            | i_nmi_wd_timeout, "nmi");
         check(o_nonmaskable_event, |rnd[117:114] & rnd[118],
            "nmi event");
         check(o_nonmaskable_watchdog_reset_request, i_nmi_wd_expired,
            "nmi wd");
         check(o_software_reset_to_wd, {2{i_software_reset_request}},
            "sw");
         check(o_watchdog_reset_requests, i_wd_expired, "wd");
         check(o_busfault_precise, i_precise_fault, "precise");
         check(o_busfault_imprecise, exp_imp, "imprecise");
         check(o_irq_lines, exp_irq(), "irq");
         check(o_adc_eoc_and, i_adc1_eoc & i_adc2_eoc, "eoc");
      end
      // Reset after relocation, with a slow boot memory
      set_base(1'b1, 32'h0000_1000);
      slow = 1'b1;
      @(posedge i_ref_clk);
      do_reset;
      lookup(8'h01);
      lookup(8'h10);
      stop_test;
   end
endmodule

// file: vector_routing_pkg.sv
// Shared constants and types for exception vectoring and event routing
package vector_routing_pkg;
   // Vector numbers of the table slots
   localparam logic [7:0]  VEC_STACK      = 8'h00;
   localparam logic [7:0]  VEC_RESET      = 8'h01;
   localparam logic [7:0]  VEC_NMI        = 8'h02;
   localparam logic [7:0]  VEC_HARD_FAULT = 8'h03;
   localparam logic [7:0]  VEC_RSVD_LO    = 8'h07;
   localparam logic [7:0]  VEC_RSVD_HI    = 8'h0A;
   localparam logic [7:0]  VEC_RSVD_MID   = 8'h0D;
   localparam logic [7:0]  VEC_FIRST_IRQ  = 8'h10;
   localparam logic [7:0]  VEC_LAST_IRQ   = 8'h6B;
   localparam int          NUM_VECTORS    = 108;
   localparam int          NUM_IRQ        = 92;
   // Slot offset is vector number times four
   localparam int          SLOT_SHIFT     = 2;
   // Table base handling
   localparam logic [31:0] BASE_AT_RESET  = 32'h0000_0000;
   localparam logic [31:0] BASE_MIN       = 32'h0000_0200;
   localparam logic [31:0] BASE_MAX       = 32'h3FFF_FE00;
   localparam logic [8:0]  BASE_ALIGN_MSK = 9'h1FF;
   // Fixed and default priorities
   localparam logic signed [8:0] PRIO_RESET = -9'sd3;
   localparam logic signed [8:0] PRIO_NMI   = -9'sd2;
   localparam logic signed [8:0] PRIO_HARD  = -9'sd1;
   localparam logic [7:0]  PRIO_DEFAULT   = 8'h00;
   // Interrupt bit positions of routed events
   localparam int          IRQ_ADC_FIRST  = 72;
   localparam int          IRQ_IPC_FIRST  = 80;
   localparam int          IRQ_RAM_SINGLE = 88;
   localparam int          IRQ_FLASH_SGL  = 90;
   localparam int          NUM_ADC_EOC    = 8;
   localparam int          NUM_IPC_IRQ    = 4;
   // Boot sequence
   typedef enum logic [1:0] {
      BOOT_STACK  = 2'b00,
      BOOT_HANDLR = 2'b01,
      BOOT_DONE   = 2'b10
   } boot_t;
endpackage
